// *** ccr_pkg.sv ***
// Package with register map, field positions and reset values of the block.
package ccr_pkg;

    // Number of comparator instances.
    localparam int unsigned NUM_CMP = 3;

    // Printed register indices; byte address is four times the index.
    localparam logic [7:0] IDX_CONTROL = 8'h88;
    localparam logic [7:0] IDX_MODE = 8'h89;
    // Page-0 interrupt registers.
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h00;
    localparam logic [7:0] IDX_EXT_IRQ_EN = 8'h01;

    // Register pages: comparator n lives on page n plus one.
    localparam logic [1:0] PAGE_IRQ = 2'h0;
    localparam logic [1:0] PAGE_FIRST_CMP = 2'h1;

    // Byte address layout: [11:10] page, [9:2] index.
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned PAGE_LSB = 10;
    localparam int unsigned IDX_LSB = 2;

    // Control register fields.
    localparam int unsigned CTL_ON = 7;
    localparam int unsigned CTL_RESULT = 6;
    localparam int unsigned CTL_RISE = 5;
    localparam int unsigned CTL_FALL = 4;
    localparam int unsigned CTL_PHYST_LSB = 2;
    localparam int unsigned CTL_NHYST_LSB = 0;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // Bits that software stores directly (on and both hysteresis fields).
    localparam logic [7:0] CTL_WMASK = 8'h8F;

    // Mode register fields.
    localparam int unsigned MD_RISE_IE = 5;
    localparam int unsigned MD_FALL_IE = 4;
    localparam int unsigned MD_RESP_LSB = 0;
    localparam logic [7:0] MD_RESET = 8'h02;
    localparam logic [7:0] MD_WMASK = 8'h33;

    // Interrupt status: [2:0] sticky events, [6:4] live request terms.
    localparam int unsigned IST_REQ_LSB = 4;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register decode result.
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_CONTROL,
        SEL_MODE,
        SEL_IRQ_STATUS,
        SEL_EXT_IRQ_EN
    } ccr_sel_t;

endpackage : ccr_pkg

// *** ccr_comparator_control.sv ***
// Control and status registers for three analog comparators over AXI4-Lite.
`timescale 1ns/1ps
module ccr_comparator_control (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [11:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [11:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire logic [2:0] i_compare_raw,
    output logic [2:0] o_comparator_on,
    output logic [5:0] o_positive_hyst_sel,
    output logic [5:0] o_negative_hyst_sel,
    output logic [5:0] o_response_mode_sel,
    output logic [2:0] o_compare_pin,
    output logic o_irq
);

    // Decode a byte address into a register kind.
    function automatic ccr_pkg::ccr_sel_t decode_sel(
        input logic [11:0] addr
    );
        logic [1:0] page;
        logic [7:0] idx;
        page = addr[ccr_pkg::PAGE_LSB +: 2];
        idx = addr[ccr_pkg::IDX_LSB +: 8];
        decode_sel = ccr_pkg::SEL_NONE;
        if (addr[1:0] != 2'h0) begin
            decode_sel = ccr_pkg::SEL_NONE;
        end else if (page == ccr_pkg::PAGE_IRQ) begin
            if (idx == ccr_pkg::IDX_IRQ_STATUS) begin
                decode_sel = ccr_pkg::SEL_IRQ_STATUS;
            end else if (idx == ccr_pkg::IDX_EXT_IRQ_EN) begin
                decode_sel = ccr_pkg::SEL_EXT_IRQ_EN;
            end
        end else if (idx == ccr_pkg::IDX_CONTROL) begin
            decode_sel = ccr_pkg::SEL_CONTROL;
        end else if (idx == ccr_pkg::IDX_MODE) begin
            decode_sel = ccr_pkg::SEL_MODE;
        end
    endfunction : decode_sel

    // Comparator instance addressed by a comparator page.
    function automatic logic [1:0] decode_cmp(input logic [11:0] addr);
        decode_cmp = 2'(addr[ccr_pkg::PAGE_LSB +: 2]
            - ccr_pkg::PAGE_FIRST_CMP);
    endfunction : decode_cmp

    // Register state.
    logic [7:0] ctrl_q [3], ctrl_d [3];
    logic [7:0] mode_q [3], mode_d [3];
    logic [2:0] irq_stat_q, irq_stat_d;
    logic [2:0] ext_en_q, ext_en_d;

    // Synchroniser and edge detector state.
    logic [2:0] sync1_q, sync2_q, prev_q;
    logic [2:0] result, rise, fall, req;

    // Bus state.
    logic aw_held_q, aw_held_d;
    logic w_held_q, w_held_d;
    logic [11:0] awaddr_q, awaddr_d;
    logic [7:0] wdata_q, wdata_d;
    logic wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic do_write;
    ccr_pkg::ccr_sel_t wsel;
    logic [1:0] wcmp;

    // two-stage synchroniser
    // The raw analog result is asynchronous to the bus clock.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            prev_q <= 3'h0;
        end else begin
            sync1_q <= i_compare_raw;
            sync2_q <= sync1_q;
            prev_q <= result;
        end
    end

    // Result, edges and request terms per comparator.
    always_comb begin
        for (int n = 0; n < 3; n++) begin
            result[n] = sync2_q[n] & ctrl_q[n][ccr_pkg::CTL_ON];
            rise[n] = result[n] & ~prev_q[n];
            fall[n] = ~result[n] & prev_q[n];
            req[n] = (ctrl_q[n][ccr_pkg::CTL_RISE]
                    & mode_q[n][ccr_pkg::MD_RISE_IE])
                | (ctrl_q[n][ccr_pkg::CTL_FALL]
                    & mode_q[n][ccr_pkg::MD_FALL_IE]);
        end
    end

    // Write channel acceptance; one write is finished before the next.
    assign do_write = aw_held_q & w_held_q & ~bvalid_q;
    assign wsel = decode_sel(awaddr_q);
    assign wcmp = decode_cmp(awaddr_q);

    // Next values of the write path and its response.
    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_held_d = 1'b1;
            awaddr_d = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_held_d = 1'b1;
            wdata_d = i_s_axi_wdata[7:0];
            wstrb_d = i_s_axi_wstrb[0];
        end
        if (do_write) begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (wsel == ccr_pkg::SEL_NONE) ? ccr_pkg::RESP_SLVERR
                : ccr_pkg::RESP_OKAY;
        end else if (bvalid_q && i_s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    // Register file next values; hardware sets win over software clears.
    always_comb begin
        logic wr_byte;
        wr_byte = do_write & wstrb_q;
        irq_stat_d = irq_stat_q;
        ext_en_d = ext_en_q;
        for (int n = 0; n < 3; n++) begin
            logic wr_here;
            wr_here = wr_byte && (wcmp == 2'(n));
            ctrl_d[n] = ctrl_q[n];
            mode_d[n] = mode_q[n];
            if (wr_here && wsel == ccr_pkg::SEL_CONTROL) begin
                ctrl_d[n] = (ctrl_q[n] & ~ccr_pkg::CTL_WMASK)
                    | (wdata_q & ccr_pkg::CTL_WMASK);
                if (!wdata_q[ccr_pkg::CTL_RISE]) begin
                    ctrl_d[n][ccr_pkg::CTL_RISE] = 1'b0;
                end
                if (!wdata_q[ccr_pkg::CTL_FALL]) begin
                    ctrl_d[n][ccr_pkg::CTL_FALL] = 1'b0;
                end
            end
            if (rise[n]) begin
                ctrl_d[n][ccr_pkg::CTL_RISE] = 1'b1;
            end
            if (fall[n]) begin
                ctrl_d[n][ccr_pkg::CTL_FALL] = 1'b1;
            end
            ctrl_d[n][ccr_pkg::CTL_RESULT] = result[n];
            if (wr_here && wsel == ccr_pkg::SEL_MODE) begin
                mode_d[n] = wdata_q & ccr_pkg::MD_WMASK;
            end
            // Sticky status: write one clears, a new event wins.
            if (wr_byte && wsel == ccr_pkg::SEL_IRQ_STATUS
                    && wdata_q[n]) begin
                irq_stat_d[n] = 1'b0;
            end
            if ((rise[n] && mode_q[n][ccr_pkg::MD_RISE_IE])
                    || (fall[n] && mode_q[n][ccr_pkg::MD_FALL_IE])) begin
                irq_stat_d[n] = 1'b1;
            end
        end
        if (wr_byte && wsel == ccr_pkg::SEL_EXT_IRQ_EN) begin
            ext_en_d = wdata_q[2:0];
        end
    end

    // Read path: one read at a time, data latched at the address handshake.
    always_comb begin
        ccr_pkg::ccr_sel_t rsel;
        logic [1:0] rcmp;
        rsel = decode_sel(i_s_axi_araddr);
        rcmp = decode_cmp(i_s_axi_araddr);
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (i_s_axi_arvalid && o_s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = ccr_pkg::RESP_OKAY;
            rdata_d = 32'h0000_0000;
            unique case (rsel)
                ccr_pkg::SEL_CONTROL: begin
                    rdata_d[7:0] = ctrl_q[rcmp];
                end
                ccr_pkg::SEL_MODE: begin
                    rdata_d[7:0] = mode_q[rcmp];
                end
                ccr_pkg::SEL_IRQ_STATUS: begin
                    rdata_d[2:0] = irq_stat_q;
                    rdata_d[ccr_pkg::IST_REQ_LSB +: 3] = req;
                end
                ccr_pkg::SEL_EXT_IRQ_EN: begin
                    rdata_d[2:0] = ext_en_q;
                end
                ccr_pkg::SEL_NONE: begin
                    rresp_d = ccr_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && i_s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // All register state, reset synchronously.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            for (int n = 0; n < 3; n++) begin
                ctrl_q[n] <= ccr_pkg::CTL_RESET;
                mode_q[n] <= ccr_pkg::MD_RESET;
            end
            irq_stat_q <= ccr_pkg::IRQ_RESET;
            ext_en_q <= ccr_pkg::IRQ_RESET;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 8'h00;
            wstrb_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= ccr_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= ccr_pkg::RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            mode_q <= mode_d;
            irq_stat_q <= irq_stat_d;
            ext_en_q <= ext_en_d;
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    // Bus handshake outputs; ready drops while a channel holds an item.
    assign o_s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign o_s_axi_wready = ~w_held_q & ~bvalid_q;
    assign o_s_axi_bvalid = bvalid_q;
    assign o_s_axi_bresp = bresp_q;
    assign o_s_axi_arready = ~rvalid_q;
    assign o_s_axi_rvalid = rvalid_q;
    assign o_s_axi_rresp = rresp_q;
    assign o_s_axi_rdata = rdata_q;

    // Controls sent to the analog comparators.
    always_comb begin
        for (int n = 0; n < 3; n++) begin
            o_comparator_on[n] = ctrl_q[n][ccr_pkg::CTL_ON];
            o_positive_hyst_sel[2*n +: 2] =
                ctrl_q[n][ccr_pkg::CTL_PHYST_LSB +: 2];
            o_negative_hyst_sel[2*n +: 2] =
                ctrl_q[n][ccr_pkg::CTL_NHYST_LSB +: 2];
            o_response_mode_sel[2*n +: 2] =
                mode_q[n][ccr_pkg::MD_RESP_LSB +: 2];
            o_compare_pin[n] = ctrl_q[n][ccr_pkg::CTL_RESULT];
        end
    end

    // extended enable gating
    // The ungated status stays readable so polling software still sees it.
    assign o_irq = |(irq_stat_q & ext_en_q);

endmodule : ccr_comparator_control

// *** ccr_comparator_control_assertions.sv ***
// Checker of bus handshakes and comparator outputs at the top ports.
`timescale 1ns/1ps
module ccr_comparator_control_assertions (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_s_axi_awvalid,
    input wire logic o_s_axi_awready,
    input wire logic i_s_axi_wvalid,
    input wire logic o_s_axi_wready,
    input wire logic [1:0] o_s_axi_bresp,
    input wire logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic i_s_axi_arvalid,
    input wire logic o_s_axi_arready,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire logic [2:0] i_compare_raw,
    input wire logic [2:0] o_comparator_on,
    input wire logic [5:0] o_positive_hyst_sel,
    input wire logic [5:0] o_negative_hyst_sel,
    input wire logic [5:0] o_response_mode_sel,
    input wire logic [2:0] o_compare_pin
);
    // One clock domain; nothing is judged while reset is held.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // The write executes in the cycle after both items are taken.
    property p_wr_lat;
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
            && o_s_axi_wready |-> ##2 o_s_axi_bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("no write answer");
    property p_b_hold;
        o_s_axi_bvalid && !i_s_axi_bready
            |=> o_s_axi_bvalid && $stable(o_s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_w_ref;
        o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready;
    endproperty
    a_w_ref: assert property (p_w_ref) else $error("write taken early");
    property p_rd_lat;
        i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("no read answer");
    property p_r_hold;
        o_s_axi_rvalid && !i_s_axi_rready
            |=> o_s_axi_rvalid && $stable(o_s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
    property p_ar_ref;
        o_s_axi_rvalid |-> !o_s_axi_arready;
    endproperty
    a_ar_ref: assert property (p_ar_ref) else $error("read taken early");
    // Settings move only at the edge that raises the write answer.
    property p_cfg_hold;
        $changed({o_comparator_on, o_positive_hyst_sel,
            o_negative_hyst_sel, o_response_mode_sel})
            |-> $rose(o_s_axi_bvalid);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("setting moved");
    property p_pin_off;
        (o_compare_pin & ~o_comparator_on & ~$past(o_comparator_on)) == 3'h0;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin high while off");
    property p_pin_follow;
        (o_comparator_on == 3'h7) [*4] |-> o_compare_pin == $past(i_compare_raw, 3);
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("pin lag wrong");
endmodule : ccr_comparator_control_assertions

bind ccr_comparator_control ccr_comparator_control_assertions ccr_chk_i (.*);

// *** tb.sv ***
// Self-checking bench for the comparator control registers.
`timescale 1ns/1ps
module tb;
    logic i_clk = 1'b0, i_rst_n = 1'b0;
    logic [11:0] i_s_axi_awaddr = 12'h000, i_s_axi_araddr = 12'h000;
    logic [31:0] i_s_axi_wdata = 32'h0;
    logic [3:0] i_s_axi_wstrb = 4'hF;
    logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
    logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
    logic [2:0] i_compare_raw = 3'h0;
    logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
    logic o_s_axi_rvalid, o_irq;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
    logic [31:0] o_s_axi_rdata;
    logic [2:0] o_comparator_on, o_compare_pin;
    logic [5:0] o_positive_hyst_sel, o_negative_hyst_sel, o_response_mode_sel;
    int failures = 0;
    int n_checks = 0;
    // Comparator power-up time, 10 us at 40 ns a cycle.
    localparam int POWER_UP_CYCLES = 250;

    ccr_comparator_control ccr_comparator_control_i (.*);

    // Free-running 25 MHz clock.
    initial forever #20 i_clk = ~i_clk;

    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : check

    // Bounded waits end the run as a failure when the bus hangs.
    task automatic hang();
        failures++;
        stop_test();
    endtask : hang

    function automatic logic [11:0] ctl_a(input int n);
        return 12'h620 + 12'(n) * 12'h400;
    endfunction : ctl_a

    // Address and data are offered together; each drops when taken.
    task automatic axi_wr(input logic [11:0] a, input logic [7:0] d,
            input logic [1:0] er = ccr_pkg::RESP_OKAY);
        logic aw, w, b;
        logic [1:0] r;
        int k;
        @(posedge i_clk);
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= {24'h0, d};
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid <= 1'b1;
        i_s_axi_bready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(negedge i_clk);
            aw = i_s_axi_awvalid & o_s_axi_awready;
            w = i_s_axi_wvalid & o_s_axi_wready;
            b = o_s_axi_bvalid;
            r = o_s_axi_bresp;
            @(posedge i_clk);
            if (aw) i_s_axi_awvalid <= 1'b0;
            if (w) i_s_axi_wvalid <= 1'b0;
            if (b) break;
        end
        i_s_axi_bready <= 1'b0;
        if (k == 40) hang();
        check({30'h0, r}, {30'h0, er});
    endtask : axi_wr

    task automatic axi_rd(input logic [11:0] a, input logic [7:0] ed,
            input logic [1:0] er = ccr_pkg::RESP_OKAY);
        logic ok, v;
        logic [31:0] d;
        logic [1:0] r;
        int k;
        @(posedge i_clk);
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'b1;
        i_s_axi_rready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(negedge i_clk);
            ok = i_s_axi_arvalid & o_s_axi_arready;
            v = o_s_axi_rvalid;
            d = o_s_axi_rdata;
            r = o_s_axi_rresp;
            @(posedge i_clk);
            if (ok) i_s_axi_arvalid <= 1'b0;
            if (v) break;
        end
        i_s_axi_rready <= 1'b0;
        if (k == 40) hang();
        check({30'h0, r}, {30'h0, er});
        check(d, {24'h0, ed});
    endtask : axi_rd

    task automatic idle(input int n);
        repeat (n) @(posedge i_clk);
    endtask : idle

    task automatic t_reset();
        for (int n = 0; n < 3; n++) begin
            axi_rd(ctl_a(n), 8'h00);
            axi_rd(ctl_a(n) + 12'h4, 8'h02);
        end
        check({26'h0, o_response_mode_sel}, 32'h2A);
        $display("reset test done");
    endtask : t_reset

    task automatic t_fields();
        logic [7:0] v;
        for (int n = 0; n < 3; n++) begin
            for (int c = 0; c < 4; c++) begin
                v = {4'h8, 2'(c), ~2'(c)};
                axi_wr(ctl_a(n), v);
                axi_wr(ctl_a(n) + 12'h4, {6'h3F, 2'(c)});
                check({31'h0, o_comparator_on[n]}, 32'h1);
                check({30'h0, o_positive_hyst_sel[2*n+:2]}, c);
                check({30'h0, o_negative_hyst_sel[2*n+:2]}, 3 - c);
                check({30'h0, o_response_mode_sel[2*n+:2]}, c);
                axi_rd(ctl_a(n) + 12'h4, {6'h0C, 2'(c)});
            end
            axi_wr(ctl_a(n), 8'hFF);
            axi_rd(ctl_a(n), 8'h8F);
        end
        $display("field test done");
    endtask : t_fields

    task automatic t_edges();
        i_compare_raw <= 3'h7;
        idle(6);
        check({29'h0, o_compare_pin}, 32'h7);
        for (int n = 0; n < 3; n++) axi_rd(ctl_a(n), 8'hEF);
        i_compare_raw <= 3'h0;
        idle(6);
        for (int n = 0; n < 3; n++) begin
            axi_rd(ctl_a(n), 8'hBF);
            axi_wr(ctl_a(n), 8'h80);
            axi_rd(ctl_a(n), 8'h80);
        end
        // Switching off with the input high drops the gated result.
        i_compare_raw <= 3'h7;
        idle(6);
        axi_wr(ctl_a(0), 8'h00);
        idle(4);
        check({29'h0, o_compare_pin}, 32'h6);
        axi_rd(ctl_a(0), 8'h10);
        $display("edge test done");
    endtask : t_edges

    task automatic t_irq();
        i_compare_raw <= 3'h0;
        idle(6);
        for (int n = 0; n < 3; n++) begin
            axi_wr(ctl_a(n), 8'h80);
            axi_wr(ctl_a(n) + 12'h4, n == 0 ? 8'h22 : 8'h02);
        end
        // Results are not valid until the comparators have powered up.
        idle(POWER_UP_CYCLES);
        axi_wr(12'h000, 8'h07);
        axi_rd(12'h000, 8'h00);
        i_compare_raw <= 3'h1;
        idle(6);
        axi_rd(12'h000, 8'h11);
        check({31'h0, o_irq}, 32'h0);
        axi_wr(12'h004, 8'h01);
        axi_rd(12'h004, 8'h01);
        idle(2);
        check({31'h0, o_irq}, 32'h1);
        i_compare_raw <= 3'h0;
        idle(6);
        axi_rd(12'h000, 8'h11);
        axi_wr(ctl_a(0), 8'h80);
        axi_rd(12'h000, 8'h01);
        axi_wr(12'h000, 8'h01);
        axi_rd(12'h000, 8'h00);
        check({31'h0, o_irq}, 32'h0);
        axi_wr(ctl_a(0) + 12'h4, 8'h12);
        i_compare_raw <= 3'h1;
        idle(6);
        i_compare_raw <= 3'h0;
        idle(6);
        axi_rd(12'h000, 8'h11);
        check({31'h0, o_irq}, 32'h1);
        $display("interrupt test done");
    endtask : t_irq

    task automatic t_unmapped();
        axi_rd(12'h100, 8'h00, ccr_pkg::RESP_SLVERR);
        axi_wr(12'h100, 8'hFF, ccr_pkg::RESP_SLVERR);
        axi_rd(12'h622, 8'h00, ccr_pkg::RESP_SLVERR);
        // A write with its low strobe clear leaves the register alone.
        i_s_axi_wstrb <= 4'h0;
        axi_wr(ctl_a(1), 8'h00);
        i_s_axi_wstrb <= 4'hF;
        axi_rd(ctl_a(1), 8'h80);
        $display("unmapped test done");
    endtask : t_unmapped

    // Reset for eight cycles, then run every scenario in turn.
    initial begin
        idle(8);
        i_rst_n <= 1'b1;
        t_reset();
        t_fields();
        t_edges();
        t_irq();
        t_unmapped();
        stop_test();
    end
endmodule : tb
